// *** wkc_collector.sv ***
// wake event status collector: registers, sources and wake output
`timescale 1ns/1ps
module wkc_collector (
    // clock and standby power-on reset
    input wire logic clk_sys,
    input wire logic rstn,
    // host i/o register access
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // first group of wake sources
    input wire logic ring_indicator_a,
    input wire logic ring_indicator_b,
    input wire logic keyboard_wake,
    input wire logic mouse_wake,
    input wire logic specific_key_wake,
    input wire logic fan_speed_wake_a,
    input wire logic fan_speed_wake_b,
    // general-purpose pins and grouped smi
    input wire logic [7:0] gpio_pin_10_17,
    input wire logic [2:0] gpio_pin_20_22,
    input wire logic grouped_smi_wake,
    input wire logic [3:0] gpio_pin_24_27,
    // wake output to the chipset, open drain
    output logic wake_out_n,
    output logic wake_out_oe_n
);
    import wkc_pkg::*;

    logic [WKC_NUM_BANKS-1:0][7:0] src_evt;
    logic [WKC_NUM_BANKS-1:0][7:0] src_flags;
    logic [WKC_NUM_BANKS-1:0] flags_wr;
    logic [WKC_NUM_BANKS-1:0] en_wr;
    logic [WKC_NUM_BANKS-1:0][7:0] src_en_q;
    logic [WKC_NUM_BANKS-1:0][7:0] src_en_d;
    logic master_en_q;
    logic master_en_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic global_flag;
    logic global_wr;

    // ****************************************
    // source mapping
    // ****************************************
    always_comb begin
        src_evt = '0;
        // bit 0 of the first register is reserved and never sets
        src_evt[0][WKC_S1_RING_B] = ring_indicator_b;
        src_evt[0][WKC_S1_RING_A] = ring_indicator_a;
        src_evt[0][WKC_S1_KEYBOARD] = keyboard_wake;
        src_evt[0][WKC_S1_MOUSE] = mouse_wake;
        src_evt[0][WKC_S1_SPECIFIC_KEY] = specific_key_wake;
        src_evt[0][WKC_S1_FAN_A] = fan_speed_wake_a;
        src_evt[0][WKC_S1_FAN_B] = fan_speed_wake_b;
        src_evt[1] = gpio_pin_10_17;
        src_evt[2][2:0] = gpio_pin_20_22;
        src_evt[2][WKC_S3_GROUPED_SMI] = grouped_smi_wake;
        src_evt[2][7:4] = gpio_pin_24_27;
    end

    // ****************************************
    // flag banks, one per source register
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < WKC_NUM_BANKS; g++) begin : g_bank
            assign flags_wr[g] = io_wr &&
                (io_addr == WKC_OFS_SRC_FLAGS_1 + 8'(g));
            assign en_wr[g] = io_wr &&
                (io_addr == WKC_OFS_SRC_ENABLE_1 + 8'(g));
            wkc_flag_bank i_wkc_flag_bank (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .evt(src_evt[g]),
                .clr_wr(flags_wr[g]),
                .clr_data(io_wdata),
                .flags(src_flags[g])
            );
        end
    endgenerate

    // ****************************************
    // enables
    // ****************************************
    assign global_wr = io_wr && (io_addr == WKC_OFS_GLOBAL_STATUS);

    always_comb begin
        src_en_d = src_en_q;
        master_en_d = master_en_q;
        for (int i = 0; i < WKC_NUM_BANKS; i++) begin
            if (en_wr[i]) begin
                src_en_d[i] = io_wdata;
            end
        end
        // upper bits of the enable register are not stored
        if (io_wr && (io_addr == WKC_OFS_GLOBAL_ENABLE)) begin
            master_en_d = io_wdata[WKC_MASTER_EN_BIT];
        end
    end

    // main-supply, soft and hard resets are not wired in at all
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            src_en_q <= {WKC_NUM_BANKS{WKC_RESET_VALUE}};
            master_en_q <= WKC_RESET_VALUE[WKC_MASTER_EN_BIT];
        end else begin
            src_en_q <= src_en_d;
            master_en_q <= master_en_d;
        end
    end

    // ****************************************
    // global flag and wake pin
    // ****************************************
    wkc_wake_drive i_wkc_wake_drive (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .src_evt(src_evt),
        .src_en(src_en_q),
        .master_en(master_en_q),
        .clr_wr(global_wr),
        .clr_bit(io_wdata[WKC_GLOBAL_FLAG_BIT]),
        .global_flag(global_flag),
        .wake_out_n(wake_out_n),
        .wake_out_oe_n(wake_out_oe_n)
    );

    // ****************************************
    // read path
    // ****************************************
    // data is registered, so it is valid the cycle after io_rd
    always_comb begin
        rdata_d = rdata_q;
        if (io_rd) begin
            case (io_addr)
                WKC_OFS_GLOBAL_STATUS:
                    rdata_d = {7'h00, global_flag};
                WKC_OFS_GLOBAL_ENABLE:
                    rdata_d = {7'h00, master_en_q};
                WKC_OFS_SRC_FLAGS_1:
                    rdata_d = src_flags[0];
                WKC_OFS_SRC_FLAGS_1 + 8'h01:
                    rdata_d = src_flags[1];
                WKC_OFS_SRC_FLAGS_1 + 8'h02:
                    rdata_d = src_flags[2];
                WKC_OFS_SRC_ENABLE_1:
                    rdata_d = src_en_q[0];
                WKC_OFS_SRC_ENABLE_1 + 8'h01:
                    rdata_d = src_en_q[1];
                WKC_OFS_SRC_ENABLE_1 + 8'h02:
                    rdata_d = src_en_q[2];
                // reserved and unmapped offsets read zero
                default:
                    rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= WKC_RESET_VALUE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign io_rdata = rdata_q;
endmodule : wkc_collector

// *** wkc_pkg.sv ***
// constants for the wake event status collector
// Contract
// - global flag set whenever wake would assert
// - global flag kept on main resets, standby zero
// - write one clears global flag, releases wake
// - master enable bit gates the wake output
// - master enable kept on main resets only
// - source flags record regardless of any enable
// - source flag sticks until software clears it
// - write one clears source flag, zero ignored
// - source flags kept on main resets, standby zero
// - register 04 holds ring, keyboard, mouse, fans
// - register 05 holds pins 10 to 17
// - register 06 holds pins 20-22, smi, 24-27
// - source reaches wake only when enabled
package wkc_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] WKC_OFS_GLOBAL_STATUS = 8'h00;
    localparam logic [7:0] WKC_OFS_RESERVED_A = 8'h01;
    localparam logic [7:0] WKC_OFS_GLOBAL_ENABLE = 8'h02;
    localparam logic [7:0] WKC_OFS_RESERVED_B = 8'h03;
    localparam logic [7:0] WKC_OFS_SRC_FLAGS_1 = 8'h04;
    localparam logic [7:0] WKC_OFS_SRC_ENABLE_1 = 8'h0A;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int WKC_NUM_BANKS = 3;
    localparam int WKC_GLOBAL_FLAG_BIT = 0;
    localparam int WKC_MASTER_EN_BIT = 0;
    localparam logic [7:0] WKC_RESET_VALUE = 8'h00;
    // source positions in the first flag register
    localparam int WKC_S1_RING_B = 1;
    localparam int WKC_S1_RING_A = 2;
    localparam int WKC_S1_KEYBOARD = 3;
    localparam int WKC_S1_MOUSE = 4;
    localparam int WKC_S1_SPECIFIC_KEY = 5;
    localparam int WKC_S1_FAN_A = 6;
    localparam int WKC_S1_FAN_B = 7;
    // grouped smi position in the third flag register
    localparam int WKC_S3_GROUPED_SMI = 3;
endpackage : wkc_pkg

// *** wkc_flag_bank.sv ***
// eight sticky write-one-to-clear wake flags
`timescale 1ns/1ps
module wkc_flag_bank (
    // clock and standby reset
    input wire logic clk_sys,
    input wire logic rstn,
    // events and clear
    input wire logic [7:0] evt,
    input wire logic clr_wr,
    input wire logic [7:0] clr_data,
    // state
    output logic [7:0] flags
);
    import wkc_pkg::*;

    logic [7:0] flags_q;
    logic [7:0] flags_d;

    // ****************************************
    // flag update
    // ****************************************
    always_comb begin
        flags_d = flags_q;
        for (int i = 0; i < 8; i++) begin
            // a clear aimed at a flag only bites when written as one
            if (clr_wr && clr_data[i]) begin
                flags_d[i] = 1'b0;
            end
            // set beats clear so an event in the clear cycle survives
            if (evt[i]) begin
                flags_d[i] = 1'b1;
            end
        end
    end

    // only standby power-on reaches here; main resets do not
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flags_q <= WKC_RESET_VALUE;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;
endmodule : wkc_flag_bank

// *** wkc_wake_drive.sv ***
// global wake flag and the active-low wake output
`timescale 1ns/1ps
module wkc_wake_drive (
    // clock and standby reset
    input wire logic clk_sys,
    input wire logic rstn,
    // sources and enables
    input wire logic [23:0] src_evt,
    input wire logic [23:0] src_en,
    input wire logic master_en,
    // software clear
    input wire logic clr_wr,
    input wire logic clr_bit,
    // state and pin
    output logic global_flag,
    output logic wake_out_n,
    output logic wake_out_oe_n
);
    import wkc_pkg::*;

    logic flag_q;
    logic flag_d;
    logic wake_q;
    logic wake_d;
    logic would_wake;

    // ****************************************
    // global flag
    // ****************************************
    // master enable is deliberately left out of the set term
    assign would_wake = |(src_evt & src_en);

    always_comb begin
        flag_d = flag_q;
        if (clr_wr && clr_bit) begin
            flag_d = 1'b0;
        end
        if (would_wake) begin
            flag_d = 1'b1;
        end
        wake_d = flag_d && master_en;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag_q <= WKC_RESET_VALUE[WKC_GLOBAL_FLAG_BIT];
            wake_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            wake_q <= wake_d;
        end
    end

    // ****************************************
    // open-drain pin
    // ****************************************
    // the pin is only ever pulled low; released means enable high
    assign global_flag = flag_q;
    assign wake_out_n = 1'b0;
    assign wake_out_oe_n = ~wake_q;
endmodule : wkc_wake_drive

// *** wkc_collector_properties.sv ***
// port assertions for the wake collector
`timescale 1ns/1ps
module wkc_collector_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register access
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // sources
    input wire logic ring_indicator_a,
    input wire logic ring_indicator_b,
    input wire logic keyboard_wake,
    input wire logic mouse_wake,
    input wire logic specific_key_wake,
    input wire logic fan_speed_wake_a,
    input wire logic fan_speed_wake_b,
    input wire logic [7:0] gpio_pin_10_17,
    input wire logic [2:0] gpio_pin_20_22,
    input wire logic grouped_smi_wake,
    input wire logic [3:0] gpio_pin_24_27,
    // wake pin
    input wire logic wake_out_n,
    input wire logic wake_out_oe_n
);
    logic any_src;
    logic en_wr;
    logic [7:0] s3;
    logic pin_wr;
    assign s3 = {gpio_pin_24_27, grouped_smi_wake, gpio_pin_20_22};
    // writes that may legally release the pin: enable change or clear
    assign pin_wr = io_wr && (io_addr == 8'h02 ||
        (io_addr == 8'h00 && io_wdata[0]));
    assign en_wr = io_wr && io_addr == 8'h02 && io_wdata[0];
    assign any_src = |{ring_indicator_a, ring_indicator_b, keyboard_wake,
        mouse_wake, specific_key_wake, fan_speed_wake_a, fan_speed_wake_b,
        gpio_pin_10_17, s3};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_pin_low: assert property (
        (!wake_out_oe_n && !pin_wr) ##1 (!wake_out_oe_n && !pin_wr) |=>
        (!wake_out_oe_n && !wake_out_n)) else $error("wake pin not held low");
    chk_rsvd_zero: assert property (
        io_rd && (io_addr == 8'h01 || io_addr == 8'h03) |=> io_rdata == 8'h00)
        else $error("reserved offset not zero");
    chk_high_bits: assert property (
        io_rd && (io_addr == 8'h00 || io_addr == 8'h02) |=> io_rdata[7:1] == 0)
        else $error("reserved bits not zero");
    chk_bit0_rsvd: assert property (
        io_rd && io_addr == 8'h04 |=> !io_rdata[0])
        else $error("flag bit 0 set");
    chk_mouse_sticks: assert property (
        mouse_wake ##1 !io_wr ##1 (io_rd && io_addr == 8'h04) |=> io_rdata[4])
        else $error("mouse flag lost");
    chk_gpio_map: assert property (
        gpio_pin_10_17 != 0 ##1 !io_wr ##1 (io_rd && io_addr == 8'h05) |=>
        (io_rdata & $past(gpio_pin_10_17, 3)) == $past(gpio_pin_10_17, 3))
        else $error("pin flags wrong");
    chk_bank3_map: assert property (
        s3 != 0 ##1 !io_wr ##1 (io_rd && io_addr == 8'h06) |=>
        (io_rdata & $past(s3, 3)) == $past(s3, 3))
        else $error("third flags wrong");
    chk_flag_clear: assert property (
        (io_wr && io_addr == 8'h04 && io_wdata == 8'hFF && !any_src) ##1
        !any_src ##1 (io_rd && io_addr == 8'h04) |=> io_rdata == 8'h00)
        else $error("flags not cleared");
    chk_clear_release: assert property (
        io_wr && io_addr == 8'h00 && io_wdata[0] && !any_src |=> wake_out_oe_n)
        else $error("pin not released");
    chk_fall_cause: assert property (
        $fell(wake_out_oe_n) |-> $past(any_src) || $past(en_wr) ||
        $past(en_wr, 2)) else $error("pin pulled without cause");
endmodule : wkc_collector_chk
bind wkc_collector wkc_collector_chk i_wkc_collector_chk (.*);

// *** wkc_host_pme.sv ***
// host wake input model: pulled-up line and wake counter
`timescale 1ns/1ps
module wkc_host_pme (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // collector pin
    input wire logic wake_out_n,
    input wire logic wake_out_oe_n,
    // observed line
    output logic pin_level,
    output logic [7:0] wake_cnt_q
);
    logic [7:0] wake_cnt_d;
    logic prev_q;
    // pull-up on the line: a released pin reads high
    assign pin_level = wake_out_oe_n ? 1'b1 : wake_out_n;
    always_comb begin
        wake_cnt_d = wake_cnt_q;
        if (prev_q && !pin_level) begin
            wake_cnt_d = wake_cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wake_cnt_q <= 8'h00;
            prev_q <= 1'b1;
        end else begin
            wake_cnt_q <= wake_cnt_d;
            prev_q <= pin_level;
        end
    end
endmodule : wkc_host_pme

// *** wkc_collector_tb_top.sv ***
// self-checking testbench for the wake collector
`timescale 1ns/1ps
module wkc_collector_tb_top;
    import wkc_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic wake_out_n;
    logic wake_out_oe_n;
    logic pin_level;
    logic [7:0] wake_cnt_q;
    logic [23:0] src = 24'h000000;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // source vector laid out like the flag registers
    wkc_collector i_wkc_collector (
        .ring_indicator_b(src[1]),
        .ring_indicator_a(src[2]),
        .keyboard_wake(src[3]),
        .mouse_wake(src[4]),
        .specific_key_wake(src[5]),
        .fan_speed_wake_a(src[6]),
        .fan_speed_wake_b(src[7]),
        .gpio_pin_10_17(src[15:8]),
        .gpio_pin_20_22(src[18:16]),
        .grouped_smi_wake(src[19]),
        .gpio_pin_24_27(src[23:20]),
        .*
    );
    wkc_host_pme i_wkc_host_pme (.*);
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge clk_sys);
        io_wr = 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk_sys);
        io_rd = 1'b1;
        io_addr = a;
        @(negedge clk_sys);
        io_rd = 1'b0;
        @(negedge clk_sys);
        check($sformatf("reg %h", a), io_rdata, exp);
    endtask : rd
    task automatic pulse(int i);
        @(negedge clk_sys);
        src[i] = 1'b1;
        @(negedge clk_sys);
        src = 24'h000000;
    endtask : pulse
    task automatic pin(logic exp);
        @(negedge clk_sys);
        check("wake oe_n", {7'h00, wake_out_oe_n}, {7'h00, exp});
        check("wake line", {7'h00, pin_level}, {7'h00, exp});
    endtask : pin
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // generous ceiling: the sequence needs well under 2000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        logic [7:0] ra;
        logic [7:0] bm;
        repeat (12) @(negedge clk_sys);
        rstn = 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd(a[7:0], 8'h00);
        end
        for (int a = 0; a < 4; a++) begin
            wr(a[7:0], 8'hFF);
            rd(a[7:0], (a == 2) ? 8'h01 : 8'h00);
        end
        wr(WKC_OFS_GLOBAL_ENABLE, 8'h00);
        $display("test reserved done");
        for (int i = 1; i < 24; i++) begin
            ra = 8'h04 + 8'(i / 8);
            bm = 8'h01 << (i % 8);
            pulse(i);
            rd(ra, bm);
            wr(ra, ~bm);
            rd(ra, bm);
            wr(ra, 8'hFF);
            rd(ra, 8'h00);
        end
        rd(WKC_OFS_GLOBAL_STATUS, 8'h00);
        $display("test source map done");
        for (int a = 10; a < 13; a++) begin
            wr(a[7:0], 8'hFF);
        end
        pulse(WKC_S1_KEYBOARD);
        pin(1'b1);
        rd(WKC_OFS_GLOBAL_STATUS, 8'h01);
        wr(WKC_OFS_GLOBAL_ENABLE, 8'h01);
        pin(1'b0);
        wr(WKC_OFS_GLOBAL_STATUS, 8'h00);
        rd(WKC_OFS_GLOBAL_STATUS, 8'h01);
        wr(WKC_OFS_GLOBAL_STATUS, 8'h01);
        pin(1'b1);
        rd(WKC_OFS_GLOBAL_STATUS, 8'h00);
        rd(WKC_OFS_GLOBAL_ENABLE, 8'h01);
        $display("test wake pin done");
        wr(WKC_OFS_SRC_ENABLE_1, 8'hF7);
        rd(WKC_OFS_SRC_ENABLE_1, 8'hF7);
        wr(WKC_OFS_SRC_FLAGS_1, 8'hFF);
        pulse(WKC_S1_KEYBOARD);
        rd(WKC_OFS_GLOBAL_STATUS, 8'h00);
        pin(1'b1);
        pulse(WKC_S1_MOUSE);
        pin(1'b0);
        check("host wakes", wake_cnt_q, 8'h02);
        $display("test source gating done");
        @(negedge clk_sys);
        rstn = 1'b0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd(a[7:0], 8'h00);
        end
        pin(1'b1);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : wkc_collector_tb_top
